/* File: rtl/logic_io_pkg.sv */
// Package for the discrete I/O function mapper: register map, function
// codes, bus carriers and the mapper's state record.
// Assumes a single 20 MHz core clock and an AXI4-Lite register master.
package logic_io_pkg;

  localparam int NUM_IN  = 5;
  localparam int NUM_OUT = 6;
  localparam int ADDR_W  = 8;
  localparam int CMD_W   = 16;

  // Register groups: address bits [7:5] pick a group, [4:2] the channel
  localparam logic [2:0] GRP_IN_SEL    = 3'h0;
  localparam logic [2:0] GRP_IN_INV    = 3'h1;
  localparam logic [2:0] GRP_IN_STATE  = 3'h2;
  localparam logic [2:0] GRP_IO_TEST   = 3'h3;
  localparam logic [2:0] GRP_OUT_SEL   = 3'h4;
  localparam logic [2:0] GRP_OUT_INV   = 3'h5;
  localparam logic [2:0] GRP_OUT_FORCE = 3'h6;
  localparam int GRP_LSB = 5;
  localparam int IDX_LSB = 2;

  // Reset values
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic        BIT_RESET = 1'b0;

  // Input function codes
  localparam logic [31:0] IN_DISABLED   = 32'h0000_0000;
  localparam logic [31:0] IN_TRIG_FIRST = 32'h0000_0002;
  localparam logic [31:0] IN_TRIG_LAST  = 32'h0000_0008;
  localparam logic [31:0] IN_CLR_REQ    = 32'h0000_000E;
  localparam logic [31:0] IN_GATE_PROD  = 32'h0000_000F;
  localparam logic [31:0] IN_GATE_FLUID = 32'h0000_0010;
  localparam logic [31:0] IN_LOCK_PANEL = 32'h0000_0011;

  // Output function codes
  localparam logic [31:0] OUT_DISABLED = 32'h0000_0000;
  localparam logic [31:0] OUT_SF_FIRST = 32'h0000_0001;
  localparam logic [31:0] OUT_SF_LAST  = 32'h0000_001C;
  localparam logic [31:0] OUT_XS_FIRST = 32'h0000_001D;
  localparam logic [31:0] OUT_XS_LAST  = 32'h0000_0023;
  localparam logic [31:0] OUT_AGITATE  = 32'h0000_0024;
  localparam int          XS_AGITATE_BIT = 9;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Master to slave
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axiMosi_t;

  // Slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axiMiso_t;

  typedef struct packed {
    logic [NUM_IN-1:0]             syncA;
    logic [NUM_IN-1:0]             syncB;
    logic [NUM_IN-1:0]             syncC;
    logic [NUM_IN-1:0]             stable;
    logic [NUM_IN-1:0]             activePrev;
    logic [NUM_IN-1:0][31:0]       inSel;
    logic [NUM_IN-1:0]             inInv;
    logic                          ioTest;
    logic [NUM_OUT-1:0][31:0]      outSel;
    logic [NUM_OUT-1:0]            outInv;
    logic [NUM_OUT-1:0]            outForce;
    logic [CMD_W-1:0]              cmd;
    logic                          panelLock;
    logic [NUM_OUT-1:0]            outPins;
    logic                          awHave;
    logic                          wHave;
    logic [ADDR_W-1:0]             awAddr;
    logic [31:0]                   wData;
    logic [3:0]                    wStrb;
    axiMiso_t                      bus;
  } mapState_t;

endpackage

/* File: rtl/logic_io_function_mapper.sv */
// Discrete I/O function mapper: five logic inputs drive command word bits
// or the panel lock, six logic outputs mirror status bits, with AXI4-Lite
// registers. Assumes status words arrive on core_clk, inputs from pins.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - An input is true while voltage is present and false while absent.
// - An input set to code zero has no effect at all.
// - Input codes two to eight drive command bits one to seven.
// - Input codes fourteen to sixteen drive command bits thirteen to 15.
// - Code seventeen locks the front panel while its input is inactive.
// - An inverted input is active while voltage is absent.
// - Each input's present active state is readable.
// - In I/O test the outputs take override values; inputs still read.
// - An output conducts while its function is true, else not.
// - An output set to code zero holds its state.
// - Output codes one to 28 mirror status flag bits zero to 27.
// - Output codes 29 to 35 mirror extended status bits zero to six.
// - Output code 36 mirrors extended status bit nine.
// - An inverted output conducts while its function is inactive.
// - In I/O test each output takes its force setting.
// the level; inputs are synchronised first.
module logic_io_function_mapper
  import logic_io_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire axiMosi_t           axiIn,
  output var  axiMiso_t           axiOut,
  input  wire logic [NUM_IN-1:0]  logicIn,
  output logic      [NUM_OUT-1:0] logicOut,
  input  wire logic [31:0]        statusFlagWord,
  input  wire logic [31:0]        extendedStatusWord,
  output logic      [CMD_W-1:0]   commandWord,
  output logic                    panelLock
);

  mapState_t stateQ;
  mapState_t stateD;

  // Status bit picked by an output code; unknown codes read false
  function automatic logic outFunction(input logic [31:0] sel,
                                       input logic [31:0] sfw,
                                       input logic [31:0] xsw);
    logic r;
    r = 1'b0;
    // Codes beyond the agitate code select nothing and read false
    if (sel >= OUT_SF_FIRST && sel <= OUT_SF_LAST)
      r = sfw[5'(sel[4:0] - OUT_SF_FIRST[4:0])];
    else if (sel >= OUT_XS_FIRST && sel <= OUT_XS_LAST)
      r = xsw[5'(sel[5:0] - OUT_XS_FIRST[5:0])];
    else if (sel == OUT_AGITATE)
      r = xsw[XS_AGITATE_BIT];
    return r;
  endfunction

  // Byte-lane merge for the 32-bit selection registers
  function automatic logic [31:0] strobeMerge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      // Lanes whose strobe is low keep their old byte
      if (strb[b])
        r[b*8 +: 8] = data[b*8 +: 8];
    end
    return r;
  endfunction

  logic [NUM_IN-1:0] active;
  logic [NUM_IN-1:0] rise;
  logic [2:0]        wGrp;
  logic [2:0]        wIdx;
  logic [2:0]        rGrp;
  logic [2:0]        rIdx;
  logic              wOk;
  logic              rOk;
  logic [31:0]       rVal;
  logic [3:0]        cmdIdx;
  logic              fn;
  // Per-input decode of the function code, rebuilt every cycle
  logic [NUM_IN-1:0] isTrig;
  logic [NUM_IN-1:0] isGate;
  logic [NUM_IN-1:0] isLock;

  // Next-state logic for the whole block
  always_comb
  begin
    stateD = stateQ;
    cmdIdx = 4'h0;
    fn     = 1'b0;
    isTrig = '0;
    isGate = '0;
    isLock = '0;

    // Three-stage synchroniser; a change counts once stages two and three
    // agree, which also rejects single-cycle glitches
    // Limitation: a pin must hold for two edges to register
    stateD.syncA = logicIn;
    stateD.syncB = stateQ.syncA;
    stateD.syncC = stateQ.syncB;
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (stateQ.syncB[i] == stateQ.syncC[i])
        stateD.stable[i] = stateQ.syncC[i];
    end

    // Voltage present means true, unless that input is inverted
    active = stateQ.stable ^ stateQ.inInv;
    rise   = active & ~stateQ.activePrev;
    // Remembered so a held level fires a trigger only once
    stateD.activePrev = active;

    // Decode each input's code once; anything unlisted stays idle
    for (int i = 0; i < NUM_IN; i++)
    begin
      isTrig[i] = (stateQ.inSel[i] >= IN_TRIG_FIRST &&
                   stateQ.inSel[i] <= IN_TRIG_LAST) ||
                  stateQ.inSel[i] == IN_CLR_REQ;
      isGate[i] = stateQ.inSel[i] == IN_GATE_PROD ||
                  stateQ.inSel[i] == IN_GATE_FLUID;
      isLock[i] = stateQ.inSel[i] == IN_LOCK_PANEL;
    end

    // Input functions; trigger bits live one cycle only
    stateD.cmd       = '0;
    stateD.panelLock = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      cmdIdx = 4'(stateQ.inSel[i][3:0] - 4'h1);
      if (isTrig[i])
        stateD.cmd[cmdIdx] = stateD.cmd[cmdIdx] | rise[i];
      else if (isGate[i])
        stateD.cmd[cmdIdx] = stateD.cmd[cmdIdx] | active[i];
      else if (isLock[i])
        stateD.panelLock = stateD.panelLock | ~active[i];
      // Code zero, unused and unknown codes fall through
      // with no command and no lock effect
    end

    // Output drive; test mode overrides every selection
    for (int j = 0; j < NUM_OUT; j++)
    begin
      // Status words share the clock, so they need no synchroniser
      fn = outFunction(stateQ.outSel[j], statusFlagWord,
                       extendedStatusWord);
      if (stateQ.ioTest)
        stateD.outPins[j] = stateQ.outForce[j];
      else if (stateQ.outSel[j] != OUT_DISABLED)
        stateD.outPins[j] = fn ^ stateQ.outInv[j];
      // Disabled output keeps whatever it last drove
    end
    // Inversion applied above flips the conducting sense
    // Input state keeps updating while test mode holds

    // Write address and data channels, taken in either order
    if (axiIn.awvalid && stateQ.bus.awready)
    begin
      stateD.awHave = 1'b1;
      stateD.awAddr = axiIn.awaddr;
    end
    if (axiIn.wvalid && stateQ.bus.wready)
    begin
      stateD.wHave = 1'b1;
      stateD.wData = axiIn.wdata;
      stateD.wStrb = axiIn.wstrb;
    end
    // Response leaves at the edge where bready is seen
    if (stateQ.bus.bvalid && axiIn.bready)
      stateD.bus.bvalid = 1'b0;

    // Perform the write once both halves are held
    // Group and channel come from the held address, not the bus
    wGrp = stateQ.awAddr[GRP_LSB +: 3];
    wIdx = stateQ.awAddr[IDX_LSB +: 3];
    wOk  = 1'b0;
    if (stateQ.awHave && stateQ.wHave && !stateQ.bus.bvalid)
    begin
      unique case (wGrp)
        // Input function codes honour every byte lane
        GRP_IN_SEL:
          if (32'(wIdx) < NUM_IN)
          begin
            wOk = 1'b1;
            stateD.inSel[wIdx] = strobeMerge(stateQ.inSel[wIdx],
                                             stateQ.wData, stateQ.wStrb);
          end
        // One-bit settings take bit zero of lane zero only
        GRP_IN_INV:
          if (32'(wIdx) < NUM_IN)
          begin
            wOk = 1'b1;
            if (stateQ.wStrb[0])
              stateD.inInv[wIdx] = stateQ.wData[0];
          end
        // Present state is live; a write is accepted and dropped
        GRP_IN_STATE:
          wOk = 32'(wIdx) < NUM_IN;                       // Read-only
        // Single test switch at channel zero
        GRP_IO_TEST:
          if (wIdx == 3'h0)
          begin
            wOk = 1'b1;
            if (stateQ.wStrb[0])
              stateD.ioTest = stateQ.wData[0];
          end
        // Output function codes honour every byte lane
        GRP_OUT_SEL:
          if (32'(wIdx) < NUM_OUT)
          begin
            wOk = 1'b1;
            stateD.outSel[wIdx] = strobeMerge(stateQ.outSel[wIdx],
                                              stateQ.wData, stateQ.wStrb);
          end
        // Output inversion, bit zero only
        GRP_OUT_INV:
          if (32'(wIdx) < NUM_OUT)
          begin
            wOk = 1'b1;
            if (stateQ.wStrb[0])
              stateD.outInv[wIdx] = stateQ.wData[0];
          end
        // Force values only matter while test mode holds
        GRP_OUT_FORCE:
          if (32'(wIdx) < NUM_OUT)
          begin
            wOk = 1'b1;
            if (stateQ.wStrb[0])
              stateD.outForce[wIdx] = stateQ.wData[0];
          end
        default:
          wOk = 1'b0;
      endcase
      // Free both halves so the next pair can be taken
      stateD.awHave     = 1'b0;
      stateD.wHave      = 1'b0;
      stateD.bus.bvalid = 1'b1;
      stateD.bus.bresp  = wOk ? RESP_OKAY : RESP_SLVERR;
    end

    // Read channel; data captured when the address is taken
    // No side effects on read, so a repeated read is harmless
    rGrp = axiIn.araddr[GRP_LSB +: 3];
    rIdx = axiIn.araddr[IDX_LSB +: 3];
    rOk  = 1'b0;
    rVal = '0;
    unique case (rGrp)
      // Selection words read back whole
      GRP_IN_SEL:
        if (32'(rIdx) < NUM_IN)
        begin
          rOk  = 1'b1;
          rVal = stateQ.inSel[rIdx];
        end
      // One-bit settings read in bit zero, upper bits zero
      GRP_IN_INV:
        if (32'(rIdx) < NUM_IN)
        begin
          rOk  = 1'b1;
          rVal = {31'h0000_0000, stateQ.inInv[rIdx]};
        end
      // State after inversion, as the functions see it
      GRP_IN_STATE:
        if (32'(rIdx) < NUM_IN)
        begin
          rOk  = 1'b1;
          rVal = {31'h0000_0000, active[rIdx]};
        end
      // Test switch
      GRP_IO_TEST:
        if (rIdx == 3'h0)
        begin
          rOk  = 1'b1;
          rVal = {31'h0000_0000, stateQ.ioTest};
        end
      // Output selection words
      GRP_OUT_SEL:
        if (32'(rIdx) < NUM_OUT)
        begin
          rOk  = 1'b1;
          rVal = stateQ.outSel[rIdx];
        end
      // Output inversion bits
      GRP_OUT_INV:
        if (32'(rIdx) < NUM_OUT)
        begin
          rOk  = 1'b1;
          rVal = {31'h0000_0000, stateQ.outInv[rIdx]};
        end
      // Output force bits
      GRP_OUT_FORCE:
        if (32'(rIdx) < NUM_OUT)
        begin
          rOk  = 1'b1;
          rVal = {31'h0000_0000, stateQ.outForce[rIdx]};
        end
      default:
        rOk = 1'b0;
    endcase
    if (stateQ.bus.rvalid && axiIn.rready)
      stateD.bus.rvalid = 1'b0;
    // A new address waits until the last read data has gone
    if (axiIn.arvalid && stateQ.bus.arready)
    begin
      stateD.bus.rvalid = 1'b1;
      stateD.bus.rdata  = rVal;
      stateD.bus.rresp  = rOk ? RESP_OKAY : RESP_SLVERR;
    end

    // Readies drop while a half is held or an answer is pending,
    // so at most one write and one read are in flight
    stateD.bus.awready = !stateD.awHave && !stateD.bus.bvalid;
    stateD.bus.wready  = !stateD.wHave && !stateD.bus.bvalid;
    stateD.bus.arready = !stateD.bus.rvalid;
  end

  // State register; everything clears on reset except the three readies, set high
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      stateQ             <= '0;
      // Selections start disabled so no pin acts before setup
      stateQ.inSel       <= {NUM_IN{SEL_RESET}};
      stateQ.outSel      <= {NUM_OUT{SEL_RESET}};
      stateQ.ioTest      <= BIT_RESET;
      // Readies idle high so the first request is taken at once
      stateQ.bus.awready <= 1'b1;
      stateQ.bus.wready  <= 1'b1;
      stateQ.bus.arready <= 1'b1;
    end
    else
      stateQ <= stateD;
  end

  // Outputs straight from the state register
  // No logic after the flops, so the pins never glitch
  assign axiOut      = stateQ.bus;
  assign logicOut    = stateQ.outPins;
  assign commandWord = stateQ.cmd;
  assign panelLock   = stateQ.panelLock;

endmodule

`default_nettype wire

/* File: verif/logic_io_mapper_properties.sv */
// Port checker for the discrete I/O mapper.
// Assumes one core_clk domain and a synchronous active-high rst.
`timescale 1ns/100ps
`default_nettype none
module logic_io_mapper_properties
  import logic_io_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst,
  input wire axiMosi_t           axiIn,
  input wire axiMiso_t           axiOut,
  input wire logic [NUM_IN-1:0]  logicIn,
  input wire logic [NUM_OUT-1:0] logicOut,
  input wire logic [31:0]        statusFlagWord,
  input wire logic [31:0]        extendedStatusWord,
  input wire logic [CMD_W-1:0]   commandWord,
  input wire logic               panelLock
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Bus steps that must be answered
  sequence wrTake;
    axiIn.awvalid && axiOut.awready && axiIn.wvalid && axiOut.wready;
  endsequence
  sequence rdTake;
    axiIn.arvalid && axiOut.arready;
  endsequence

  a_reset_clears: assert property (disable iff (1'b0)
    rst |=> commandWord == 16'h0000 && logicOut == 6'h00 && !panelLock)
    else $error("outputs not cleared by reset");
  a_unused_cmd: assert property (
    (commandWord & 16'h1F01) == 16'h0000)
    else $error("command bit without a function");
  // Triggers last one cycle, so no bit may repeat next cycle
  a_trigger_pulse: assert property (
    (commandWord & 16'h20FE) != 16'h0000
    |=> (commandWord & $past(commandWord) & 16'h20FE) == 16'h0000)
    else $error("trigger held past one cycle");
  a_write_answer: assert property (wrTake |-> ##[1:3] axiOut.bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (axiOut.bvalid && !axiIn.bready
    |=> axiOut.bvalid && $stable(axiOut.bresp))
    else $error("write response dropped");
  a_read_answer: assert property (rdTake |=> axiOut.rvalid)
    else $error("read data late");
  a_unmapped_err: assert property (axiIn.arvalid && axiOut.arready
    && axiIn.araddr[7:5] == 3'h7 |=> axiOut.rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  // Outputs move only after a status change or a register write
  a_out_cause: assert property ($changed(logicOut) |->
    $past(statusFlagWord) != $past(statusFlagWord, 2)
    || $past(extendedStatusWord) != $past(extendedStatusWord, 2)
    || !$past(axiOut.wready) || !$past(axiOut.wready, 2))
    else $error("output moved without cause");
endmodule

bind logic_io_function_mapper logic_io_mapper_properties chk_u (
  .core_clk(core_clk), .rst(rst), .axiIn(axiIn), .axiOut(axiOut),
  .logicIn(logicIn), .logicOut(logicOut),
  .statusFlagWord(statusFlagWord),
  .extendedStatusWord(extendedStatusWord),
  .commandWord(commandWord), .panelLock(panelLock));
`default_nettype wire

/* File: verif/plc_model.sv */
// PLC side of the discrete I/O: drives input pins, reads outputs.
// Assumes the bench asks for pin levels on core_clk.
`timescale 1ns/100ps
`default_nettype none
module plc_model
  import logic_io_pkg::*;
(
  input  wire logic [0:0]         core_clk,
  input  wire logic [NUM_IN-1:0]  pinReq,
  input  wire logic [NUM_OUT-1:0] logicOut,
  output logic      [NUM_IN-1:0]  logicIn,
  output logic      [NUM_OUT-1:0] seenOut
);
  // Registered scan, so pins never move on the sampling edge
  always_ff @(posedge core_clk)
  begin
    logicIn <= pinReq;
    seenOut <= logicOut;
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the discrete I/O mapper over AXI4-Lite.
// Assumes plc_model on the pins and the checker bound to the design.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import logic_io_pkg::*;
;
  typedef struct packed {
    logic [31:0] code;
    logic [31:0] sfw;
    logic [31:0] xsw;
    logic        val;
  } outRow_t;
  typedef struct packed {
    logic [31:0] code;
    logic [15:0] mask;
    logic        pulse;
  } inRow_t;
  // Output code, status words, expected pin
  localparam outRow_t OUT_ROWS [7] = '{
    '{32'h1, 32'h1, 32'h0, 1'b1}, '{32'h1C, 32'h800_0000, 32'h0, 1'b1},
    '{32'h1C, 32'hF7FF_FFFF, 32'h0, 1'b0}, '{32'h1D, 32'h0, 32'h1, 1'b1},
    '{32'h23, 32'h0, 32'h40, 1'b1}, '{32'h24, 32'h0, 32'h200, 1'b1},
    '{32'h24, 32'h0, 32'h100, 1'b0}};
  // Input code, command bits watched, one pulse expected
  localparam inRow_t IN_ROWS [13] = '{
    '{32'h2, 16'h2, 1'b1}, '{32'h3, 16'h4, 1'b1}, '{32'h4, 16'h8, 1'b1},
    '{32'h5, 16'h10, 1'b1}, '{32'h6, 16'h20, 1'b1}, '{32'h7, 16'h40, 1'b1},
    '{32'h8, 16'h80, 1'b1}, '{32'hE, 16'h2000, 1'b1},
    '{32'h0, 16'hFFFF, 1'b0}, '{32'h1, 16'hFFFF, 1'b0},
    '{32'h9, 16'hFFFF, 1'b0}, '{32'hD, 16'hFFFF, 1'b0},
    '{32'h12, 16'hFFFF, 1'b0}};
  logic               core_clk;
  logic               rst;
  axiMosi_t           mo;
  axiMiso_t           mi;
  logic [NUM_IN-1:0]  pinReq;
  logic [NUM_IN-1:0]  logicIn;
  logic [NUM_OUT-1:0] logicOut;
  logic [NUM_OUT-1:0] seenOut;
  logic [31:0]        sfw;
  logic [31:0]        xsw;
  logic [CMD_W-1:0]   commandWord;
  logic               panelLock;
  logic [31:0]        rdData;
  logic [1:0]         resp;
  int                 n_errors;
  int                 total_checks;
  int                 hits;

  // Far side model and the block under test
  plc_model plc_u (.core_clk(core_clk), .pinReq(pinReq),
    .logicOut(logicOut), .logicIn(logicIn), .seenOut(seenOut));
  logic_io_function_mapper dut_u (.core_clk(core_clk), .rst(rst),
    .axiIn(mo), .axiOut(mi), .logicIn(logicIn), .logicOut(logicOut),
    .statusFlagWord(sfw), .extendedStatusWord(xsw),
    .commandWord(commandWord), .panelLock(panelLock));

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Write: offer AW and W together, hold bready until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    mo.awaddr <= a;
    mo.wdata <= d;
    mo.awvalid <= 1'b1;
    mo.wvalid <= 1'b1;
    mo.bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (mi.awready) mo.awvalid <= 1'b0;
      if (mi.wready) mo.wvalid <= 1'b0;
    end
    while (!mi.bvalid && n < 50);
    mo.bready <= 1'b0;
    resp = mi.bresp;
    if (!mi.bvalid) chk(32'h0, 32'h1);
    if (!mi.bvalid) stop_test();
  endtask

  // Read: hold rready until rvalid, take data at that edge
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge core_clk);
    mo.araddr <= a;
    mo.arvalid <= 1'b1;
    mo.rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (mi.arready) mo.arvalid <= 1'b0;
    end
    while (!mi.rvalid && n < 50);
    mo.rready <= 1'b0;
    rdData = mi.rdata;
    resp = mi.rresp;
    if (!mi.rvalid) chk(32'h0, 32'h1);
    if (!mi.rvalid) stop_test();
  endtask

  // Main sequence: reset, table loops, then awkward cases
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    mo = '0;
    mo.wstrb = 4'hF;
    pinReq = '0;
    sfw = '0;
    xsw = '0;
    n_errors = 0;
    total_checks = 0;
    tick(20);
    rst <= 1'b0;
    for (int a = 0; a < 224; a += 32)
    begin
      rd(8'(a));
      chk(rdData, 32'h0);
    end
    for (int i = 0; i < 13; i++)
    begin
      wr(8'h00, IN_ROWS[i].code);
      pinReq <= 5'h01;
      hits = 0;
      for (int c = 0; c < 12; c++)
      begin
        @(posedge core_clk);
        if ((commandWord & IN_ROWS[i].mask) != 16'h0000) hits++;
      end
      chk(hits, 32'(IN_ROWS[i].pulse));
      pinReq <= 5'h00;
      tick(10);
    end
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h80, OUT_ROWS[i].code);
      sfw <= OUT_ROWS[i].sfw;
      xsw <= OUT_ROWS[i].xsw;
      tick(4);
      hits = int'(seenOut[0]);
      chk(hits, 32'(OUT_ROWS[i].val));
    end
    wr(8'h00, IN_GATE_PROD);
    pinReq <= 5'h01;
    tick(10);
    chk(32'(commandWord[14]), 32'h1);
    wr(8'h40, 32'h0);
    chk(32'(resp), 32'(RESP_OKAY));
    rd(8'h40);
    chk(rdData, 32'h1);
    pinReq <= 5'h00;
    wr(8'h20, 32'h1);
    wr(8'h00, IN_GATE_FLUID);
    tick(10);
    chk(32'(commandWord[15]), 32'h1);
    wr(8'h20, 32'h0);
    wr(8'h00, IN_LOCK_PANEL);
    tick(10);
    chk(32'(panelLock), 32'h1);
    pinReq <= 5'h01;
    tick(10);
    chk(32'(panelLock), 32'h0);
    wr(8'h80, OUT_SF_FIRST);
    sfw <= 32'h1;
    wr(8'h80, OUT_DISABLED);
    sfw <= 32'h0;
    tick(4);
    chk(32'(seenOut[0]), 32'h1);
    wr(8'hA0, 32'h1);
    wr(8'h80, OUT_SF_FIRST);
    tick(4);
    chk(32'(seenOut[0]), 32'h1);
    wr(8'h60, 32'h1);
    wr(8'hC4, 32'h1);
    tick(4);
    chk(32'(seenOut[1:0]), 32'h2);
    rd(8'h40);
    chk(rdData, 32'h1);
    rd(8'hE0);
    chk(rdData, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    stop_test();
  end
endmodule
`default_nettype wire
